// ### tb/vectored_irq_priority_stack_bench.sv
// Self-checking bench: both ends joined, driven over APB and the source lines
`timescale 1ns/100ps
module vectored_irq_priority_stack_bench
   import vips_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic [31:0] src_in = 32'hF000_0000;
   logic [31:0] seed = 32'h0000_79DA;
   logic [31:0] rv;
   logic [31:0] sv;
   logic [31:0] cv;
   logic [31:0] pend;
   logic [31:0] spu;
   logic [31:0] vec [2:4];
   int num_errors = 0;
   int num_checks = 0;

   always #25 mclk = ~mclk;

   vips_link_if link ();
   vips_ctrl vips_ctrl_inst (.MCLK(mclk), .RST(rst), .SRC_IN(src_in), .LINK(link));
   vips_core_side vips_core_side_inst (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(), .LINK(link));
   vips_link_assertions vips_link_assertions_inst (.MCLK(mclk), .RST(rst), .req(link.req),
      .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
      .irq_n(link.irq_n));

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      if (n >= 50)
         num_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // One device access through the command registers; waits while busy or queued
   task automatic lk(input logic w, input logic [7:0] i, input logic [31:0] d,
                     output logic [31:0] q);
      logic [31:0] s;
      int n;
      n = 0;
      apb(1'b1, VIPS_APB_TARGET, (32'(w) << VIPS_TARGET_WRITE_BIT) | 32'(i), s);
      apb(1'b1, VIPS_APB_WDATA, d, s);
      apb(1'b1, VIPS_APB_GO, 32'h0, s);
      do begin
         apb(1'b0, VIPS_APB_STATUS, 32'h0, s);
         n++;
      end while (s[1:0] !== 2'b00 && n < 20);
      // A link access that never finishes is a failure, not a silent skip
      if (n >= 20)
         num_errors++;
      apb(1'b0, VIPS_APB_RDATA, 32'h0, q);
   endtask : lk

   // Optional vector read, then current source and request line
   task automatic take(input logic rd, input logic [31:0] ev, input logic [31:0] eid,
                       input logic eirq);
      if (rd) begin
         lk(1'b0, VIPS_REG_VEC_READ, 32'h0, rv);
         check("vector", rv, ev);
      end
      lk(1'b0, VIPS_REG_CUR_ID, 32'h0, rv);
      check("current id", rv, eid);
      apb(1'b0, VIPS_APB_STATUS, 32'h0, rv);
      check("irq line", {31'h0, rv[2]}, {31'h0, eirq});
   endtask : take

   initial begin
      #(50 * 40000);
      num_errors++;
      stop_test();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      lk(1'b0, VIPS_REG_SPURIOUS, 32'h0, rv);
      check("spurious reset", rv, VIPS_SPU_RESET);
      spu = rnd();
      lk(1'b1, VIPS_REG_SPURIOUS, spu, rv);
      lk(1'b0, VIPS_REG_SPURIOUS, 32'h0, rv);
      check("spurious rw", rv, spu);
      lk(1'b1, VIPS_REG_SET_CMD, 32'hFFFF_FFFF, rv);
      lk(1'b0, VIPS_REG_PEND_MAP, 32'h0, rv);
      check("set all", rv, VIPS_IMPL_MAP);
      lk(1'b1, VIPS_REG_CLEAR_CMD, 32'hFFFF_FFFF, rv);
      pend = 32'h0;
      // Nothing enabled yet, so pending sources must not raise the request
      for (int k = 0; k < 6; k++) begin
         sv = rnd();
         cv = rnd();
         lk(1'b1, VIPS_REG_SET_CMD, sv, rv);
         lk(1'b1, VIPS_REG_CLEAR_CMD, cv, rv);
         pend = (pend | sv) & ~cv & VIPS_IMPL_MAP;
         lk(1'b0, VIPS_REG_PEND_MAP, 32'h0, rv);
         check("pending map", rv, pend);
         apb(1'b0, VIPS_APB_STATUS, 32'h0, rv);
         check("masked irq", {31'h0, rv[2]}, 32'h0);
      end
      lk(1'b1, VIPS_REG_CLEAR_CMD, 32'hFFFF_FFFF, rv);
      for (int k = 2; k <= 4; k++) begin
         vec[k] = rnd();
         lk(1'b1, VIPS_REG_SRC_MODE + 8'(k), (k == 4) ? 32'h25 : 32'h23, rv);
         lk(1'b1, VIPS_REG_SRC_VEC + 8'(k), vec[k], rv);
      end
      lk(1'b1, VIPS_REG_ENABLE_CMD, 32'h1C, rv);
      lk(1'b1, VIPS_REG_SET_CMD, 32'h0C, rv);
      take(1'b0, 32'h0, 32'h0, 1'b1);
      take(1'b1, vec[2], 32'h2, 1'b0);
      lk(1'b0, VIPS_REG_PEND_MAP, 32'h0, rv);
      check("edge cleared", rv, 32'h08);
      lk(1'b1, VIPS_REG_SET_CMD, 32'h10, rv);
      take(1'b0, 32'h0, 32'h2, 1'b1);
      take(1'b1, vec[4], 32'h4, 1'b0);
      lk(1'b1, VIPS_REG_EOI_CMD, rnd(), rv);
      take(1'b0, 32'h0, 32'h2, 1'b0);
      lk(1'b1, VIPS_REG_EOI_CMD, rnd(), rv);
      take(1'b0, 32'h0, 32'h0, 1'b1);
      take(1'b1, vec[3], 32'h3, 1'b0);
      lk(1'b1, VIPS_REG_EOI_CMD, 32'h0, rv);
      take(1'b1, 32'h0, 32'h0, 1'b0);
      // External line as rising edge: the rise that follows a fall must latch
      lk(1'b1, VIPS_REG_SRC_MODE + 8'(VIPS_EXTERNAL0_SRC_BIT), 32'h61, rv);
      src_in[31] <= 1'b0;
      repeat (8) @(posedge mclk);
      src_in[31] <= 1'b1;
      repeat (8) @(posedge mclk);
      lk(1'b0, VIPS_REG_PEND_MAP, 32'h0, rv);
      check("rising edge", rv, 32'h8000_0000);
      lk(1'b1, VIPS_REG_CLEAR_CMD, 32'h8000_0000, rv);
      lk(1'b0, VIPS_REG_PEND_MAP, 32'h0, rv);
      check("edge clear", rv, 32'h0);
      apb(1'b1, VIPS_APB_CORE, 32'h0, rv);
      lk(1'b1, VIPS_REG_SET_CMD, 32'h10, rv);
      for (int n = 0; n < 40 && rv[3] !== 1'b1; n++)
         apb(1'b0, VIPS_APB_STATUS, 32'h0, rv);
      apb(1'b0, VIPS_APB_VECTOR, 32'h0, rv);
      check("taken vector", rv, vec[4]);
      apb(1'b0, VIPS_APB_CORE, 32'h0, rv);
      check("disable set", rv, 32'h1);
      lk(1'b1, VIPS_REG_EOI_CMD, 32'h0, rv);
      take(1'b0, 32'h0, 32'h0, 1'b0);
      lk(1'b1, VIPS_REG_DISABLE_CMD, 32'hFFFF_FFFF, rv);
      lk(1'b1, VIPS_REG_SET_CMD, 32'h1C, rv);
      take(1'b1, 32'h0, 32'h0, 1'b0);
      // Level source: the vector read must not clear it, only the line itself can
      lk(1'b1, VIPS_REG_SRC_MODE + 8'h05, 32'h04, rv);
      lk(1'b1, VIPS_REG_SRC_VEC + 8'h05, ~spu, rv);
      lk(1'b1, VIPS_REG_ENABLE_CMD, 32'h20, rv);
      src_in[5] <= 1'b1;
      repeat (8) @(posedge mclk);
      take(1'b1, ~spu, 32'h5, 1'b0);
      lk(1'b0, VIPS_REG_PEND_MAP, 32'h0, rv);
      check("level kept", rv, 32'h3C);
      src_in[5] <= 1'b0;
      repeat (8) @(posedge mclk);
      lk(1'b1, VIPS_REG_EOI_CMD, rnd(), rv);
      take(1'b0, 32'h0, 32'h0, 1'b0);
      lk(1'b0, VIPS_REG_PEND_MAP, 32'h0, rv);
      check("level dropped", rv, 32'h1C);
      stop_test();
   end
endmodule : vectored_irq_priority_stack_bench

// ### tb/vips_link_assertions.sv
// Concurrent checks on the link between the controller and its core-side end
`timescale 1ns/100ps
module vips_link_assertions
   import vips_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic req,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   input wire logic ack,
   input wire logic irq_n
);
   logic [31:0] en_reg;

   // Mirror of the enable map, kept from the enable and disable commands seen on the link
   always_ff @(posedge MCLK) begin
      if (RST)
         en_reg <= 32'h0;
      else if (req && !ack && wr && addr == VIPS_REG_ENABLE_CMD)
         en_reg <= en_reg | wdata;
      else if (req && !ack && wr && addr == VIPS_REG_DISABLE_CMD)
         en_reg <= en_reg & ~wdata;
   end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   sequence vec_take;
      req && !ack && !wr && addr == VIPS_REG_VEC_READ;
   endsequence

   sequence masked_idle;
      (en_reg & VIPS_NORMAL_MAP) == 32'h0 && irq_n;
   endsequence

   a_ack_follows_req: assert property (req && !ack |=> ack)
      else $error("link ack missing after request");
   a_ack_single_pulse: assert property (ack |=> !ack)
      else $error("link ack longer than one cycle");
   a_ack_has_cause: assert property (ack |-> $past(req) && !$past(ack))
      else $error("link ack without request");
   a_req_fields_held: assert property (req && !ack |=> $stable(addr) && $stable(wr) && $stable(wdata))
      else $error("link request changed before ack");
   a_vec_drops_irq: assert property (vec_take |=> irq_n)
      else $error("request still raised after vector read");
   a_masked_stays_quiet: assert property ((en_reg & VIPS_NORMAL_MAP) == 32'h0 [*4] |-> irq_n)
      else $error("request raised with all sources disabled");
   a_masked_read_zero: assert property (vec_take ##0 masked_idle |=> rdata == 32'h0)
      else $error("vector read nonzero with nothing to take");
   a_reset_idle_link: assert property ($fell(RST) |-> irq_n && !ack && rdata == 32'h0)
      else $error("link not idle after reset");
endmodule : vips_link_assertions

// ### verilog/vips_core_side.sv
// Core-side end: APB command registers, link master and request taking
`timescale 1ns/100ps
module vips_core_side
   import vips_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   vips_link_if.core LINK
);
   typedef struct packed {
      vips_state_t state;
      logic pready;
      logic [31:0] prdata;
      logic [8:0] target;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic go;
      logic dis;
      logic [31:0] vector;
      logic taken;
      logic auto_rd;
      logic req;
      logic wr;
      logic [7:0] addr;
      logic [31:0] lwdata;
   } vips_core_t;

   vips_core_t r_reg;
   vips_core_t r_next;

   always_comb begin
      logic setup_hit;
      logic commit;
      setup_hit = PSEL & PENABLE & ~r_reg.pready;
      commit = PSEL & PENABLE & r_reg.pready;
      r_next = r_reg;
      r_next.pready = setup_hit;
      if (setup_hit && !PWRITE) begin
         unique case (PADDR)
            VIPS_APB_TARGET: r_next.prdata = {23'h0, r_reg.target};
            VIPS_APB_WDATA: r_next.prdata = r_reg.wdata;
            VIPS_APB_RDATA: r_next.prdata = r_reg.rdata;
            VIPS_APB_STATUS: r_next.prdata = {28'h0, r_reg.taken, ~LINK.irq_n,
                                              r_reg.go, r_reg.state == VIPS_ACCESS};
            VIPS_APB_CORE: r_next.prdata = {31'h0, r_reg.dis};
            VIPS_APB_VECTOR: r_next.prdata = r_reg.vector;
            default: r_next.prdata = 32'h0000_0000;
         endcase
      end
      if (commit && PWRITE) begin
         unique case (PADDR)
            VIPS_APB_TARGET: r_next.target = PWDATA[8:0];
            VIPS_APB_WDATA: r_next.wdata = PWDATA;
            // A start while one is queued is dropped; status shows it queued
            VIPS_APB_GO: r_next.go = 1'b1;
            VIPS_APB_CORE: r_next.dis = PWDATA[0];
            VIPS_APB_VECTOR: r_next.taken = 1'b0;
            default: ;
         endcase
      end
      unique case (r_reg.state)
         VIPS_IDLE: begin
            // Taking the request outranks queued software accesses
            if (!LINK.irq_n && !r_reg.dis) begin
               r_next.req = 1'b1;
               r_next.wr = 1'b0;
               r_next.addr = VIPS_REG_VEC_READ;
               r_next.auto_rd = 1'b1;
               r_next.state = VIPS_ACCESS;
            end else if (r_reg.go) begin
               r_next.req = 1'b1;
               r_next.wr = r_reg.target[VIPS_TARGET_WRITE_BIT];
               r_next.addr = r_reg.target[7:0];
               r_next.lwdata = r_reg.wdata;
               r_next.auto_rd = 1'b0;
               r_next.go = 1'b0;
               r_next.state = VIPS_ACCESS;
            end
         end
         VIPS_ACCESS: begin
            if (LINK.ack) begin
               r_next.req = 1'b0;
               r_next.state = VIPS_IDLE;
               if (r_reg.auto_rd) begin
                  r_next.vector = LINK.rdata;
                  r_next.taken = 1'b1;
                  r_next.dis = 1'b1;
               end else begin
                  r_next.rdata = LINK.rdata;
               end
            end
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         r_reg <= '0;
         r_reg.state <= VIPS_IDLE;
         r_reg.dis <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign PRDATA = r_reg.prdata;
   assign PREADY = r_reg.pready;
   assign PSLVERR = 1'b0;
   assign LINK.req = r_reg.req;
   assign LINK.wr = r_reg.wr;
   assign LINK.addr = r_reg.addr;
   assign LINK.wdata = r_reg.lwdata;
endmodule : vips_core_side

// ### verilog/vips_ctrl.sv
// Vectored prioritised interrupt controller with level stack
`timescale 1ns/100ps
module vips_ctrl
   import vips_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic [31:0] SRC_IN,
   vips_link_if.dev LINK
);
   typedef struct packed {
      logic [31:0][31:0] vec;
      logic [31:0][7:0] mode;
      logic [31:0] pend;
      logic [31:0] en;
      logic [31:0] s1;
      logic [31:0] s2;
      logic [31:0] s3;
      logic [31:0] spu;
      logic [VIPS_STACK_DEPTH-1:0][7:0] stk;
      logic [3:0] depth;
      logic ack;
      logic [31:0] rdata;
      logic irq_n;
   } vips_dev_t;

   vips_dev_t r_reg;
   vips_dev_t r_next;

   always_comb begin
      logic [31:0] lvl_act;
      logic [31:0] edge_hit;
      logic [31:0] is_edge;
      logic [31:0] pend_eff;
      logic [31:0] cand;
      logic [31:0] clr;
      logic [31:0] setv;
      logic found;
      logic [4:0] best;
      logic [2:0] best_prio;
      logic [2:0] prio_i;
      logic [2:0] top;
      logic [2:0] cur_lvl;
      logic [4:0] cur_src;
      logic preempt;
      logic hit;
      logic rd_vec;
      lvl_act = '0;
      edge_hit = '0;
      is_edge = '0;
      found = 1'b0;
      best = 5'h0;
      best_prio = 3'h0;
      prio_i = 3'h0;
      clr = '0;
      setv = '0;
      r_next = r_reg;
      // Sources arrive from other logic blocks and pins: two flops first
      r_next.s1 = SRC_IN;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      for (int i = 0; i < 32; i++) begin
         is_edge[i] = r_reg.mode[i][VIPS_MODE_TYPE_LSB];
         if (VIPS_EXT_MAP[i] && !r_reg.mode[i][VIPS_MODE_TYPE_LSB+1]) begin
            lvl_act[i] = ~r_reg.s2[i];
            edge_hit[i] = r_reg.s3[i] & ~r_reg.s2[i];
         end else begin
            lvl_act[i] = r_reg.s2[i];
            edge_hit[i] = r_reg.s2[i] & ~r_reg.s3[i];
         end
      end
      edge_hit = edge_hit & is_edge & VIPS_IMPL_MAP;
      // Level sources show the live line; only the source itself can drop it
      pend_eff = (r_reg.pend | (lvl_act & ~is_edge)) & VIPS_IMPL_MAP;
      cand = pend_eff & r_reg.en & VIPS_NORMAL_MAP;
      // Strictly greater keeps the lowest-numbered source on a tie
      for (int i = 1; i < 32; i++) begin
         prio_i = r_reg.mode[i][VIPS_MODE_PRIO_LSB +: 3];
         if (cand[i] && (!found || prio_i > best_prio)) begin
            found = 1'b1;
            best = 5'(i);
            best_prio = prio_i;
         end
      end
      top = r_reg.depth[2:0] - 3'h1;
      cur_lvl = r_reg.stk[top][7:5];
      cur_src = r_reg.stk[top][4:0];
      preempt = found && (r_reg.depth == 4'h0 || best_prio > cur_lvl);
      hit = LINK.req & ~r_reg.ack;
      rd_vec = hit && !LINK.wr && LINK.addr == VIPS_REG_VEC_READ;
      r_next.ack = hit;
      r_next.rdata = VIPS_REG_RESET;
      if (hit && LINK.wr) begin
         if (LINK.addr[7:5] == VIPS_REG_SRC_MODE[7:5]) begin
            r_next.mode[LINK.addr[4:0]] = LINK.wdata[7:0] & VIPS_MODE_MASK;
         end else if (LINK.addr[7:5] == VIPS_REG_SRC_VEC[7:5]) begin
            r_next.vec[LINK.addr[4:0]] = LINK.wdata;
         end else begin
            unique case (LINK.addr)
               VIPS_REG_ENABLE_CMD: r_next.en = (r_reg.en | LINK.wdata) & VIPS_IMPL_MAP;
               VIPS_REG_DISABLE_CMD: r_next.en = r_reg.en & ~LINK.wdata;
               VIPS_REG_CLEAR_CMD: clr = LINK.wdata;
               VIPS_REG_SET_CMD: setv = LINK.wdata;
               VIPS_REG_EOI_CMD: begin
                  // Data is ignored: the write itself is the event
                  if (r_reg.depth != 4'h0) begin
                     r_next.depth = r_reg.depth - 4'h1;
                  end
               end
               VIPS_REG_SPURIOUS: r_next.spu = LINK.wdata;
               default: ;
            endcase
         end
      end
      if (hit && !LINK.wr) begin
         if (LINK.addr[7:5] == VIPS_REG_SRC_MODE[7:5]) begin
            r_next.rdata = {24'h0, r_reg.mode[LINK.addr[4:0]]};
         end else if (LINK.addr[7:5] == VIPS_REG_SRC_VEC[7:5]) begin
            r_next.rdata = r_reg.vec[LINK.addr[4:0]];
         end else begin
            unique case (LINK.addr)
               VIPS_REG_VEC_READ: begin
                  if (preempt) begin
                     r_next.rdata = r_reg.vec[best];
                  end else if (!r_reg.irq_n) begin
                     r_next.rdata = r_reg.spu;
                  end else begin
                     r_next.rdata = VIPS_REG_RESET;
                  end
               end
               VIPS_REG_CUR_ID: begin
                  if (r_reg.depth != 4'h0) begin
                     r_next.rdata = {27'h0, cur_src};
                  end
               end
               VIPS_REG_PEND_MAP: r_next.rdata = pend_eff;
               VIPS_REG_ENABLE_MAP: r_next.rdata = r_reg.en;
               VIPS_REG_LINE_STAT: r_next.rdata = {30'h0, ~r_reg.irq_n, 1'b0};
               VIPS_REG_SPURIOUS: r_next.rdata = r_reg.spu;
               default: r_next.rdata = VIPS_REG_RESET;
            endcase
         end
      end
      // A vector read with a winner pushes it unless the stack is full; a spurious one pushes nothing
      if (rd_vec && preempt) begin
         if (r_reg.depth != 4'(VIPS_STACK_DEPTH)) begin
            r_next.stk[r_reg.depth[2:0]] = {best_prio, best};
            r_next.depth = r_reg.depth + 4'h1;
         end
         if (is_edge[best]) begin
            clr[best] = 1'b1;
         end
      end
      // New edges and set commands win over a clear in the same cycle
      r_next.pend = ((r_reg.pend & ~clr) | edge_hit | setv) & VIPS_IMPL_MAP;
      // Drop the request on the read; next cycle sees the pushed level
      r_next.irq_n = rd_vec ? 1'b1 : ~preempt;
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         r_reg <= '0;
         r_reg.spu <= VIPS_SPU_RESET;
         r_reg.irq_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign LINK.rdata = r_reg.rdata;
   assign LINK.ack = r_reg.ack;
   assign LINK.irq_n = r_reg.irq_n;
endmodule : vips_ctrl

// ### verilog/vips_link_if.sv
// Register and request link between interrupt controller and core side
`timescale 1ns/100ps
interface vips_link_if;
   logic req;
   logic wr;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic ack;
   logic irq_n;
   modport dev (input req, input wr, input addr, input wdata,
                output rdata, output ack, output irq_n);
   modport core (output req, output wr, output addr, output wdata,
                 input rdata, input ack, input irq_n);
endinterface : vips_link_if

// ### verilog/vips_pkg.sv
// Constants and types shared by both ends of the vectored interrupt link
// Operation
// - Clear command: ones clear pending, zeros ignored
// - Set command: ones force pending, zeros ignored
// - Command bit map: fast, software, peripherals, externals
// - Any end-of-interrupt write ends current interrupt
// - Spurious vector register, read/write, resets zero
// - Vector read makes best pending source current
// - Vector read drops request; software must read
// - Vector read clears edge-triggered selected source
// - Vector read pushes new level on stack
// - Vector read returns selected source handler address
// - Higher pending enabled source re-raises request
// - Handler clears level sources at the source
// - Software writes end-of-interrupt after every service
// - End-of-interrupt pops stack, restores previous level
// - After pop, pending source above restored level re-raises
// - Core takes request only while disable bit clear
// - Core sets disable bit when it takes the request
// - No current interrupt: current-ID read returns zero
// - Two-bit trigger type per source
// - Only enabled sources join selection and requests
package vips_pkg;
   // Device register word indices on the link
   localparam logic [7:0] VIPS_REG_SRC_MODE = 8'h00;
   localparam logic [7:0] VIPS_REG_SRC_VEC = 8'h20;
   localparam logic [7:0] VIPS_REG_VEC_READ = 8'h40;
   localparam logic [7:0] VIPS_REG_CUR_ID = 8'h41;
   localparam logic [7:0] VIPS_REG_PEND_MAP = 8'h42;
   localparam logic [7:0] VIPS_REG_ENABLE_MAP = 8'h43;
   localparam logic [7:0] VIPS_REG_LINE_STAT = 8'h44;
   localparam logic [7:0] VIPS_REG_ENABLE_CMD = 8'h45;
   localparam logic [7:0] VIPS_REG_DISABLE_CMD = 8'h46;
   localparam logic [7:0] VIPS_REG_CLEAR_CMD = 8'h47;
   localparam logic [7:0] VIPS_REG_SET_CMD = 8'h48;
   localparam logic [7:0] VIPS_REG_EOI_CMD = 8'h49;
   localparam logic [7:0] VIPS_REG_SPURIOUS = 8'h4A;
   // Source mode fields
   localparam int VIPS_MODE_PRIO_LSB = 0;
   localparam int VIPS_MODE_TYPE_LSB = 5;
   localparam logic [7:0] VIPS_MODE_MASK = 8'h67;
   // Source bit map
   localparam int VIPS_FAST_SRC_BIT = 0;
   localparam int VIPS_SOFTWARE_SRC_BIT = 1;
   localparam int VIPS_PORT_B_SRC_BIT = 14;
   localparam int VIPS_EXTERNAL3_SRC_BIT = 28;
   localparam int VIPS_EXTERNAL0_SRC_BIT = 31;
   localparam logic [31:0] VIPS_IMPL_MAP = 32'hF0007FFF;
   localparam logic [31:0] VIPS_NORMAL_MAP = 32'hF0007FFE;
   localparam logic [31:0] VIPS_EXT_MAP = 32'hF0000000;
   localparam int VIPS_STACK_DEPTH = 8;
   localparam logic [31:0] VIPS_SPU_RESET = 32'h0000_0000;
   localparam logic [31:0] VIPS_REG_RESET = 32'h0000_0000;
   // Controller APB byte offsets
   localparam logic [7:0] VIPS_APB_TARGET = 8'h00;
   localparam logic [7:0] VIPS_APB_WDATA = 8'h04;
   localparam logic [7:0] VIPS_APB_GO = 8'h08;
   localparam logic [7:0] VIPS_APB_RDATA = 8'h0C;
   localparam logic [7:0] VIPS_APB_STATUS = 8'h10;
   localparam logic [7:0] VIPS_APB_CORE = 8'h14;
   localparam logic [7:0] VIPS_APB_VECTOR = 8'h18;
   localparam int VIPS_TARGET_WRITE_BIT = 8;

   typedef enum logic [1:0] {VIPS_IDLE, VIPS_ACCESS} vips_state_t;
endpackage : vips_pkg
